// File: fsc_host_model.sv
// fsc_host_model: host controller model driving the fail-safe register port
module fsc_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic reg_write_en,
	output logic reg_read_en,
	output logic [3:0] reg_addr,
	output logic [23:0] reg_wdata,
	input wire logic [23:0] reg_rdata_q,
	input wire logic reg_rdata_valid_q
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] SIMPLE_ANSWER = 16'h5AB2;
	initial begin
		reg_write_en = 1'b0;
		reg_read_en = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 24'h000000;
	end
	// idle address and data are inverted so nothing stale looks valid
	task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = {d, 8'h00};
		reg_write_en = 1'b1;
		@(posedge clk);
		#1;
		reg_write_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask : write_reg
	task automatic read_reg(input logic [3:0] a, output logic [15:0] d, output logic ok);
		int n;
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_read_en = 1'b1;
		@(posedge clk);
		#1;
		reg_read_en = 1'b0;
		reg_addr = ~a;
		n = 0;
		while (reg_rdata_valid_q !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		ok = (reg_rdata_valid_q === 1'b1);
		d = reg_rdata_q[23:8];
	endtask : read_reg
	task automatic clear_status(input logic [15:0] bits);
		write_reg(4'h9, bits);
	endtask : clear_status
	function automatic logic [15:0] challenger_answer(input logic [15:0] seed);
		logic [17:0] t;
		t = ~(({2'b00, seed} * 18'h00004) + 18'h00006 - 18'h00004);
		return t[17:2];
	endfunction : challenger_answer
endmodule : fsc_host_model

// File: fsc_pkg.sv
// fsc_pkg: register indices, field layouts and reset values of the fail-safe register bank
package fsc_pkg;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam int FRAME_WIDTH = 24;
	localparam int DATA_LSB = 8;
	localparam int DATA_MSB = 23;
	localparam int ADDR_WIDTH = 4;

	// ------------------------------------------------------------
	// register indices on the internal register port
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_REACTION_ONE = 4'h0;
	localparam logic [3:0] IDX_REACTION_TWO = 4'h1;
	localparam logic [3:0] IDX_WD_CONFIG = 4'h2;
	localparam logic [3:0] IDX_SAFETY_INPUT = 4'h3;
	localparam logic [3:0] IDX_FSM_CONFIG = 4'h4;
	localparam logic [3:0] IDX_SCALING = 4'h5;
	localparam logic [3:0] IDX_WD_WINDOW = 4'h6;
	localparam logic [3:0] IDX_SEED_SHIFT_REGISTER_SEED_VALUE = 4'h7;
	localparam logic [3:0] IDX_HOST_ANSWER_VALUE = 4'h8;
	localparam logic [3:0] IDX_RAIL_STATUS = 4'h9;

	// ------------------------------------------------------------
	// reset values and writable masks (data bits 15:0 = frame 23:8)
	// ------------------------------------------------------------
	localparam logic [15:0] RST_REACTION_ONE = 16'hD00D;
	localparam logic [15:0] MSK_REACTION_ONE = 16'hF7EF;
	localparam logic [15:0] RST_REACTION_TWO = 16'hDDDD;
	localparam logic [15:0] MSK_REACTION_TWO = 16'hFFFF;
	localparam logic [15:0] RST_WD_CONFIG = 16'h4200;
	localparam logic [15:0] MSK_WD_CONFIG = 16'hDB00;
	localparam logic [15:0] RST_SAFETY_INPUT = 16'h41C6;
	localparam logic [15:0] MSK_SAFETY_INPUT = 16'hDDDE;
	localparam logic [15:0] RST_FSM_CONFIG = 16'h5080;
	localparam logic [15:0] MSK_FSM_CONFIG = 16'hDAB0;
	localparam logic [15:0] RST_SCALING = 16'h0000;
	localparam logic [15:0] MSK_SCALING = 16'hF800;
	localparam logic [15:0] RST_WD_WINDOW = 16'h320B;
	localparam logic [15:0] MSK_WD_WINDOW = 16'hF70F;
	localparam logic [15:0] RST_SEED_SHIFT_REGISTER_SEED_VALUE = 16'h5AB2;
	localparam logic [15:0] RST_HOST_ANSWER_VALUE = 16'h0000;
	localparam logic [15:0] RST_RAIL_STATUS = 16'h5550;
	localparam logic [15:0] MSK_RAIL_STATUS = 16'hFFF6;

	// ------------------------------------------------------------
	// field positions inside the 16 data bits
	// ------------------------------------------------------------
	localparam int POS_WATCHDOG_ERROR_THRESHOLD = 14;
	localparam int POS_REFRESH_THRESHOLD = 11;
	localparam int POS_WD_REACTION = 8;
	localparam int POS_WD_RFR_COUNT = 4;
	localparam int POS_WD_ERR_COUNT = 0;
	localparam int POS_FAULT_MODE = 14;
	localparam int POS_FLT_LIMIT = 14;
	localparam int POS_FLT_REACTION = 11;
	localparam int POS_PULSE_SEL = 9;
	localparam int POS_SHORT_RESET = 7;
	localparam int POS_CLK_MON_OFF = 5;
	localparam int POS_LONG_LOW_OFF = 4;
	localparam int POS_FLT_COUNT = 0;
	localparam int POS_SCALING = 11;
	localparam int POS_WIN_PERIOD = 12;
	localparam int POS_WIN_DUTY = 8;
	localparam int POS_WIN_RECOVERY = 0;
	localparam int POS_STATUS_REF = 2;
	localparam int POS_STATUS_OSC = 1;
	localparam int RAIL_COUNT = 6;

endpackage : fsc_pkg

// File: fsc_regs.sv
// fsc_regs: fail-safe configuration and status register bank
//
// Overview of operation
// [R1] Watchdog config reads the live 3-bit refresh counter in bits 14:12.
// [R2] Watchdog config reads the live 4-bit error counter in bits 11:8.
// [R3] State-machine config reads the live fault error counter in bits 11:8.
// [R4] Pulse length bit selects 10 ms when clear, 1.0 ms when set.
// [R5] Bit 15 set makes a failsafe output short-high request a reset.
// [R6] Bit 13 of state-machine config turns clock supervision off.
// [R7] Bit 12 of state-machine config turns the 8 s low timer off.
// [R8] Five-bit scaling field in bits 23:19 selects negative offset steps.
// [R9] Seed register holds SEED_SHIFT_REGISTER state in bits 23:8, resets to 0x5AB2.
// [R10] Host answers challenger mode with inverted SEED_SHIFT_REGISTER arithmetic result.
// [R11] Host answers simple mode by writing 0x5AB2 to the answer register.
// [R12] Answer register is write-only, 16 bits in 23:8, resets to zero.
// [R13] Each rail overvoltage flag sets on report and stays until cleared.
// [R14] Undervoltage flags set on report; they leave reset set, overvoltage cleared.
// [R15] Flags clear on a written one and reload their reset value on reset; written zero keeps them.
// [R16] Second reaction register holds eight 2-bit external monitor reactions.
// [R17] Watchdog config holds error limit, refresh limit and safety reaction fields.
// [R18] Safety-input register holds mode, polarities, reactions and acknowledge time.
// [R19] State-machine config holds fault counter limit and fault reaction fields.
// [R20] Window register holds period, duty cycle and recovery window fields.
// [R21] Per-rail selftest bits choose testing during the second analog selftest.
// [R22] Unused and read-only bits ignore writes; reserved bits read zero.
// [R23] Data sits in frame bits 23:8; all state returns to reset values.
module fsc_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port from the serial control interface
	input wire logic reg_write_en,
	input wire logic reg_read_en,
	input wire logic [3:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata_q,
	output logic reg_rdata_valid_q,
	// live counters from the watchdog and state-machine engines
	input wire logic [2:0] refresh_count_value,
	input wire logic [3:0] watchdog_error_count_value,
	input wire logic [3:0] fault_error_count_value,
	input wire logic seed_shift_register_update,
	input wire logic [15:0] seed_shift_register_update_value,
	// monitor reports, asynchronous to clk
	input wire logic [5:0] rail_over_event,
	input wire logic [5:0] rail_under_event,
	input wire logic reference_over_event,
	input wire logic oscillator_drift_event,
	input wire logic failsafe_short_high,
	// monitor configuration
	output logic [7:0] core_io_reaction_q,
	output logic [15:0] rail_reaction_q,
	output logic [5:0] selftest_select_q,
	// watchdog configuration
	output logic [1:0] watchdog_error_threshold_q,
	output logic [1:0] refresh_threshold_q,
	output logic [1:0] watchdog_safety_reaction_q,
	output logic [3:0] window_period_sel_q,
	output logic [2:0] window_duty_sel_q,
	output logic [3:0] recovery_window_sel_q,
	output logic [15:0] seed_shift_register_seed_value_q,
	output logic [15:0] host_answer_value_q,
	output logic answer_strobe_q,
	// safety inputs
	output logic [1:0] fault_input_mode_q,
	output logic [2:0] input_polarity_q,
	output logic [2:0] input_reaction_q,
	output logic error_monitor_polarity_q,
	output logic [1:0] error_monitor_ack_time_q,
	output logic error_monitor_reaction_q,
	// state-machine options
	output logic [1:0] fault_counter_threshold_q,
	output logic [1:0] fault_counter_reaction_q,
	output logic reset_pulse_length_sel_q,
	output logic reset_on_failsafe_short_q,
	output logic clock_supervision_off_q,
	output logic long_low_timer_off_q,
	output logic reset_request_q,
	// scaling and status
	output logic [4:0] voltage_scaling_step_q,
	output logic [15:0] rail_status_q
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic fsc_hit(input logic [3:0] addr, input logic [3:0] idx);
		fsc_hit = (addr == idx);
	endfunction : fsc_hit

	// writable bits take the new value, the rest keep the old one
	function automatic logic [15:0] fsc_merge(input logic [15:0] old_val,
		input logic [15:0] new_val, input logic [15:0] mask);
		fsc_merge = (old_val & ~mask) | (new_val & mask);
	endfunction : fsc_merge

	logic [15:0] wr_data;
	logic wr_react1, wr_react2, wr_wdcfg, wr_safe, wr_fsm;
	logic wr_scale, wr_window, wr_seed, wr_answer, wr_status;

	assign wr_data = reg_wdata[fsc_pkg::DATA_MSB:fsc_pkg::DATA_LSB]; // R23
	assign wr_react1 = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_REACTION_ONE);
	assign wr_react2 = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_REACTION_TWO);
	assign wr_wdcfg = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_WD_CONFIG);
	assign wr_safe = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_SAFETY_INPUT);
	assign wr_fsm = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_FSM_CONFIG);
	assign wr_scale = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_SCALING);
	assign wr_window = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_WD_WINDOW);
	assign wr_seed = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_SEED_SHIFT_REGISTER_SEED_VALUE);
	assign wr_answer = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_HOST_ANSWER_VALUE);
	assign wr_status = reg_write_en && fsc_hit(reg_addr, fsc_pkg::IDX_RAIL_STATUS);

	// ------------------------------------------------------------
	// configuration storage
	// ------------------------------------------------------------
	logic [15:0] react1_q, react2_q, wdcfg_q, safe_q, fsm_q, scale_q, window_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			react1_q <= fsc_pkg::RST_REACTION_ONE; // R23
		end else if (wr_react1) begin
			react1_q <= fsc_merge(react1_q, wr_data, fsc_pkg::MSK_REACTION_ONE); // R21
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			react2_q <= fsc_pkg::RST_REACTION_TWO;
		end else if (wr_react2) begin
			react2_q <= fsc_merge(react2_q, wr_data, fsc_pkg::MSK_REACTION_TWO); // R16
		end
	end

	// counter bits 6:0 are never stored; they are live on read
	always_ff @(posedge clk) begin
		if (reset) begin
			wdcfg_q <= fsc_pkg::RST_WD_CONFIG;
		end else if (wr_wdcfg) begin
			wdcfg_q <= fsc_merge(wdcfg_q, wr_data, fsc_pkg::MSK_WD_CONFIG); // R17 R22
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			safe_q <= fsc_pkg::RST_SAFETY_INPUT;
		end else if (wr_safe) begin
			safe_q <= fsc_merge(safe_q, wr_data, fsc_pkg::MSK_SAFETY_INPUT); // R18
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fsm_q <= fsc_pkg::RST_FSM_CONFIG;
		end else if (wr_fsm) begin
			fsm_q <= fsc_merge(fsm_q, wr_data, fsc_pkg::MSK_FSM_CONFIG); // R19 R4 R6 R7
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			scale_q <= fsc_pkg::RST_SCALING;
		end else if (wr_scale) begin
			scale_q <= fsc_merge(scale_q, wr_data, fsc_pkg::MSK_SCALING); // R8
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			window_q <= fsc_pkg::RST_WD_WINDOW;
		end else if (wr_window) begin
			window_q <= fsc_merge(window_q, wr_data, fsc_pkg::MSK_WD_WINDOW); // R20
		end
	end

	// ------------------------------------------------------------
	// watchdog seed and answer
	// ------------------------------------------------------------
	// the engine's own SEED_SHIFT_REGISTER step beats a host write in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			seed_shift_register_seed_value_q <= fsc_pkg::RST_SEED_SHIFT_REGISTER_SEED_VALUE; // R9
		end else if (seed_shift_register_update) begin
			seed_shift_register_seed_value_q <= seed_shift_register_update_value;
		end else if (wr_seed) begin
			seed_shift_register_seed_value_q <= wr_data; // R9
		end
	end

	// answer checking (challenger or simple) belongs to the watchdog engine
	always_ff @(posedge clk) begin
		if (reset) begin
			host_answer_value_q <= fsc_pkg::RST_HOST_ANSWER_VALUE; // R12
			answer_strobe_q <= 1'b0;
		end else begin
			answer_strobe_q <= wr_answer; // R10 R11
			if (wr_answer) begin
				host_answer_value_q <= wr_data; // R12
			end
		end
	end

	// ------------------------------------------------------------
	// monitor reports and sticky status
	// ------------------------------------------------------------
	logic [5:0] over_sync, under_sync;
	logic ref_sync, osc_sync, short_sync;
	logic [15:0] status_set, status_clear;

	fsc_sync2 #(
		.WIDTH(15)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in({failsafe_short_high, oscillator_drift_event, reference_over_event,
			rail_under_event, rail_over_event}),
		.sync_q({short_sync, osc_sync, ref_sync, under_sync, over_sync})
	);

	// rail k pairs at bits 15-2i (over) and 14-2i (under), core first
	always_comb begin
		status_set = '0;
		for (int i = 0; i < fsc_pkg::RAIL_COUNT; i++) begin
			status_set[15 - 2 * i] = over_sync[5 - i]; // R13
			status_set[14 - 2 * i] = under_sync[5 - i]; // R14
		end
		status_set[fsc_pkg::POS_STATUS_REF] = ref_sync;
		status_set[fsc_pkg::POS_STATUS_OSC] = osc_sync;
	end

	assign status_clear = wr_status ? (wr_data & fsc_pkg::MSK_RAIL_STATUS) : '0; // R15

	fsc_sticky_flags #(
		.WIDTH(16),
		.RESET_VALUE(fsc_pkg::RST_RAIL_STATUS)
	) u_status (
		.clk(clk),
		.reset(reset),
		.set_vec(status_set),
		.clear_vec(status_clear),
		.flags_q(rail_status_q)
	);

	// ------------------------------------------------------------
	// reset request on failsafe short
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			reset_request_q <= 1'b0;
		end else begin
			reset_request_q <= short_sync && fsm_q[fsc_pkg::POS_SHORT_RESET]; // R5
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [15:0] rd_data;

	always_comb begin
		rd_data = '0;
		case (reg_addr)
			fsc_pkg::IDX_REACTION_ONE: rd_data = react1_q;
			fsc_pkg::IDX_REACTION_TWO: rd_data = react2_q;
			fsc_pkg::IDX_WD_CONFIG: begin
				rd_data = wdcfg_q;
				rd_data[fsc_pkg::POS_WD_RFR_COUNT +: 3] = refresh_count_value; // R1
				rd_data[fsc_pkg::POS_WD_ERR_COUNT +: 4] = watchdog_error_count_value; // R2
			end
			fsc_pkg::IDX_SAFETY_INPUT: rd_data = safe_q;
			fsc_pkg::IDX_FSM_CONFIG: begin
				rd_data = fsm_q;
				rd_data[fsc_pkg::POS_FLT_COUNT +: 4] = fault_error_count_value; // R3
			end
			fsc_pkg::IDX_SCALING: rd_data = scale_q;
			fsc_pkg::IDX_WD_WINDOW: rd_data = window_q;
			fsc_pkg::IDX_SEED_SHIFT_REGISTER_SEED_VALUE: rd_data = seed_shift_register_seed_value_q;
			fsc_pkg::IDX_RAIL_STATUS: rd_data = rail_status_q;
			default: rd_data = '0; // R22
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata_q <= '0;
			reg_rdata_valid_q <= 1'b0;
		end else begin
			reg_rdata_valid_q <= reg_read_en;
			if (reg_read_en) begin
				reg_rdata_q <= {rd_data, 8'h00}; // R23
			end
		end
	end

	// ------------------------------------------------------------
	// field outputs
	// ------------------------------------------------------------
	assign core_io_reaction_q = {react1_q[15:12], react1_q[3:0]};
	assign selftest_select_q = {react1_q[10:5]}; // R21
	assign rail_reaction_q = react2_q;
	assign watchdog_error_threshold_q = wdcfg_q[fsc_pkg::POS_WATCHDOG_ERROR_THRESHOLD +: 2];
	assign refresh_threshold_q = wdcfg_q[fsc_pkg::POS_REFRESH_THRESHOLD +: 2];
	assign watchdog_safety_reaction_q = wdcfg_q[fsc_pkg::POS_WD_REACTION +: 2];
	assign fault_input_mode_q = safe_q[fsc_pkg::POS_FAULT_MODE +: 2];
	assign input_polarity_q = safe_q[12:10];
	assign input_reaction_q = {safe_q[8], safe_q[7], safe_q[6]};
	assign error_monitor_polarity_q = safe_q[4];
	assign error_monitor_ack_time_q = safe_q[3:2];
	assign error_monitor_reaction_q = safe_q[1];
	assign fault_counter_threshold_q = fsm_q[fsc_pkg::POS_FLT_LIMIT +: 2];
	assign fault_counter_reaction_q = fsm_q[fsc_pkg::POS_FLT_REACTION +: 2];
	assign reset_pulse_length_sel_q = fsm_q[fsc_pkg::POS_PULSE_SEL];
	assign reset_on_failsafe_short_q = fsm_q[fsc_pkg::POS_SHORT_RESET];
	assign clock_supervision_off_q = fsm_q[fsc_pkg::POS_CLK_MON_OFF];
	assign long_low_timer_off_q = fsm_q[fsc_pkg::POS_LONG_LOW_OFF];
	assign voltage_scaling_step_q = scale_q[fsc_pkg::POS_SCALING +: 5];
	assign window_period_sel_q = window_q[fsc_pkg::POS_WIN_PERIOD +: 4];
	assign window_duty_sel_q = window_q[fsc_pkg::POS_WIN_DUTY +: 3];
	assign recovery_window_sel_q = window_q[fsc_pkg::POS_WIN_RECOVERY +: 4];

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_status_write;
		wr_status && (status_set == 16'h0000);
	endsequence

	sequence s_answer_write;
		answer_strobe_q && (host_answer_value_q == $past(wr_data));
	endsequence

	a_seed_after_reset: assert property (disable iff (1'b0) reset |=> // R9
		seed_shift_register_seed_value_q == 16'h5AB2)
		else $error("seed not loaded with start value after reset");

	a_status_start: assert property (disable iff (1'b0) reset |=> // R14
		rail_status_q == 16'h5550)
		else $error("status flags wrong after reset");

	a_flag_set_wins: assert property ((status_set != 16'h0000) |=> // R13
		((rail_status_q & $past(status_set)) == $past(status_set)))
		else $error("reported event did not set its flag");

	a_flag_holds: assert property (!wr_status |=> // R13
		((rail_status_q & $past(rail_status_q)) == $past(rail_status_q)))
		else $error("status flag dropped without a clear");

	a_flag_w1c: assert property (s_status_write |=> // R15
		((rail_status_q & $past(wr_data) & 16'hFFF6) == 16'h0000) &&
		((rail_status_q & ~$past(wr_data)) == ($past(rail_status_q) & ~$past(wr_data))))
		else $error("write one did not clear or write zero changed a flag");

	a_answer_taken: assert property (wr_answer |=> s_answer_write ##1 // R12
		(!answer_strobe_q || $past(wr_answer)))
		else $error("answer not captured with a single strobe");

	a_answer_reads_zero: assert property ((reg_read_en && reg_addr == 4'h8) |=> // R12
		(reg_rdata_valid_q && reg_rdata_q == 24'h000000))
		else $error("answer register did not read as zero");

	a_wd_counters_read: assert property ((reg_read_en && reg_addr == 4'h2) |=> // R1 R2
		(reg_rdata_q[14:12] == $past(refresh_count_value)) &&
		(reg_rdata_q[11:8] == $past(watchdog_error_count_value)) && (reg_rdata_q[7:0] == 8'h00))
		else $error("watchdog counters not shown on read");

	a_fault_count_read: assert property ((reg_read_en && reg_addr == 4'h4) |=> // R3
		(reg_rdata_q[11:8] == $past(fault_error_count_value)))
		else $error("fault counter not shown on read");

	a_short_reset: assert property ((short_sync && reset_on_failsafe_short_q) |=> // R5
		reset_request_q)
		else $error("short high did not request a reset");

	a_short_no_reset: assert property (!reset_on_failsafe_short_q |=> // R5
		!reset_request_q)
		else $error("reset requested while short reset disabled");

	a_fsm_options: assert property (wr_fsm |=> // R4 R6 R7
		(clock_supervision_off_q == $past(reg_wdata[13])) &&
		(long_low_timer_off_q == $past(reg_wdata[12])) &&
		(reset_pulse_length_sel_q == $past(reg_wdata[17])))
		else $error("state-machine option bits not written");

	a_scaling_mask: assert property (wr_scale |=> // R8 R22
		(voltage_scaling_step_q == $past(reg_wdata[23:19])) && (scale_q[10:0] == 11'h000))
		else $error("scaling field wrong or reserved bits written");

endmodule : fsc_regs

// File: fsc_sticky_flags.sv
// fsc_sticky_flags: vector of sticky flags, set by hardware and cleared by writing one
module fsc_sticky_flags #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// set and clear strobes
	input wire logic [WIDTH-1:0] set_vec,
	input wire logic [WIDTH-1:0] clear_vec,
	output logic [WIDTH-1:0] flags_q
);

	logic [WIDTH-1:0] flags_d;

	// set wins over a clear in the same cycle, so no event is lost
	always_comb begin
		flags_d = (flags_q & ~clear_vec) | set_vec;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			flags_q <= RESET_VALUE;
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule : fsc_sticky_flags

// File: fsc_sync2.sv
// fsc_sync2: two-flop synchroniser for levels arriving from the analog monitors
module fsc_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_q
);

	logic [WIDTH-1:0] meta_q;

	// meta_q feeds sync_q only
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule : fsc_sync2

// File: test_failsafe_config_status_regs.sv
// test_failsafe_config_status_regs: self-checking bench for the fail-safe register bank
module test_failsafe_config_status_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset, we, re, lu, fsh, refe, osce, strobe, rv, rreq, pls, sho, cko, llo, ok, emp, emr;
	logic [7:0] cir;
	logic [3:0] addr, wec, fec, wps, rws;
	logic [2:0] rfc, wds, ipo, ire;
	logic [23:0] wdata, rdata;
	logic [15:0] luv, rr, ans, st, rd, lsv;
	logic [5:0] ove, uve, sts;
	logic [1:0] wet, rft, wsr, fim, emat, fct, fcr;
	logic [4:0] svs;
	int miscompares, checks;
	logic [15:0] rst_tab [0:9] = '{16'hD00D, 16'hDDDD, 16'h4200, 16'h41C6, 16'h5080,
		16'h0000, 16'h320B, 16'h5AB2, 16'h0000, 16'h5550};
	logic [15:0] msk_tab [0:7] = '{16'hF7EF, 16'hFFFF, 16'hDB00, 16'hDDDE, 16'hDAB0,
		16'hF800, 16'hF70F, 16'hFFFF};
	fsc_host_model host (.clk(clk), .reg_write_en(we), .reg_read_en(re), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rdata_valid_q(rv));
	fsc_regs DUT (.clk(clk), .reset(reset), .reg_write_en(we), .reg_read_en(re),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rdata_valid_q(rv),
		.refresh_count_value(rfc), .watchdog_error_count_value(wec),
		.fault_error_count_value(fec), .seed_shift_register_update(lu), .seed_shift_register_update_value(luv),
		.rail_over_event(ove), .rail_under_event(uve), .reference_over_event(refe),
		.oscillator_drift_event(osce), .failsafe_short_high(fsh), .core_io_reaction_q(cir),
		.rail_reaction_q(rr), .selftest_select_q(sts), .watchdog_error_threshold_q(wet),
		.refresh_threshold_q(rft), .watchdog_safety_reaction_q(wsr),
		.window_period_sel_q(wps), .window_duty_sel_q(wds), .recovery_window_sel_q(rws),
		.seed_shift_register_seed_value_q(lsv), .host_answer_value_q(ans), .answer_strobe_q(strobe),
		.fault_input_mode_q(fim), .input_polarity_q(ipo), .input_reaction_q(ire),
		.error_monitor_polarity_q(emp), .error_monitor_ack_time_q(emat),
		.error_monitor_reaction_q(emr), .fault_counter_threshold_q(fct),
		.fault_counter_reaction_q(fcr), .reset_pulse_length_sel_q(pls),
		.reset_on_failsafe_short_q(sho), .clock_supervision_off_q(cko),
		.long_low_timer_off_q(llo), .reset_request_q(rreq), .voltage_scaling_step_q(svs),
		.rail_status_q(st));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string msg);
		host.read_reg(a, rd, ok);
		chk({31'h00000000, ok}, 32'h00000001, "read answer");
		chk({16'h0000, rd}, {16'h0000, exp}, msg);
	endtask : rd_chk
	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	// a hung run is cut here and counted as a mismatch
	initial begin
		#200000;
		miscompares++;
		$display("wrong value at %0t: run did not finish", $time);
		end_sim();
	end
	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	initial begin
		int i;
		reset = 1'b1;
		{lu, fsh, refe, osce} = 4'h0;
		{rfc, wec, fec} = 11'h000;
		{ove, uve} = 12'h000;
		luv = 16'h0000;
		miscompares = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		#1;
		reset = 1'b0;
		for (i = 0; i < 10; i++) begin
			rd_chk(i[3:0], rst_tab[i], "reset value");
		end
		rd_chk(4'hA, 16'h0000, "unmapped read");
		chk({pls, sho, cko, llo, svs}, 9'h080, "reset options");
		$display("test reset values done");
		{rfc, wec, fec} = {3'h7, 4'h8, 4'hC};
		rd_chk(4'h2, 16'h4278, "watchdog counters");
		rd_chk(4'h4, 16'h508C, "fault counter");
		{rfc, wec, fec} = 11'h000;
		$display("test live counters done");
		for (i = 0; i < 8; i++) begin
			host.write_reg(i[3:0], 16'hFFFF);
			rd_chk(i[3:0], msk_tab[i], "writable bits");
		end
		chk(rr, 16'hFFFF, "monitor reactions");
		chk(sts, 6'h3F, "selftest select");
		chk({wet, rft, wsr, wps, wds, rws}, 17'h1FFFF, "watchdog fields");
		chk({cir, ipo, ire, emp, emr}, 16'hFFFF, "reaction and input fields");
		chk({fim, emat, fct, fcr, pls, sho, cko, llo}, 12'hFFF, "options");
		host.write_reg(4'h5, 16'h8000);
		chk(svs, 5'h10, "scaling top code");
		host.write_reg(4'hF, 16'hFFFF);
		rd_chk(4'hF, 16'h0000, "unmapped write");
		reset = 1'b1;
		@(posedge clk);
		#1;
		reset = 1'b0;
		rd_chk(4'h5, 16'h0000, "scaling after reset");
		$display("test register fields done");
		lu = 1'b1;
		luv = 16'h1234;
		@(posedge clk);
		#1;
		lu = 1'b0;
		rd_chk(4'h7, 16'h1234, "engine seed");
		chk(lsv, 16'h1234, "seed output");
		host.write_reg(4'h8, host.SIMPLE_ANSWER);
		chk({strobe, ans}, 17'h15AB2, "simple answer");
		@(posedge clk);
		#1;
		chk(strobe, 1'b0, "answer strobe ends");
		host.write_reg(4'h8, host.challenger_answer(16'h1234));
		chk(ans, 16'hEDCB, "challenger answer");
		rd_chk(4'h8, 16'h0000, "answer reads zero");
		$display("test watchdog seed and answer done");
		{ove, uve, refe, osce} = 14'h3FFF;
		repeat (5) @(posedge clk);
		host.clear_status(16'h0000);
		rd_chk(4'h9, 16'hFFF6, "flags set");
		{ove, uve, refe, osce} = 14'h0000;
		repeat (4) @(posedge clk);
		host.clear_status(16'hAAA0);
		rd_chk(4'h9, 16'h5556, "overvoltage cleared");
		host.clear_status(16'hFFFF);
		chk(st, 16'h0000, "all flags cleared");
		$display("test status flags done");
		host.write_reg(4'h4, 16'h0080);
		chk({pls, sho, cko, llo}, 4'h4, "single option");
		fsh = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk(rreq, 1'b1, "short reset on");
		host.write_reg(4'h4, 16'h0000);
		repeat (2) @(posedge clk);
		#1;
		chk(rreq, 1'b0, "short reset off");
		$display("test short reset done");
		end_sim();
	end
endmodule : test_failsafe_config_status_regs
